/* File: pic_host_pkg.sv */
// Shared constants and types for the interrupt controller host front end.
// Assumes a single 100 MHz clock and pins already synchronous to it.
package pic_host_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WR_NS       = 190;
  localparam int T_RD_NS       = 160;
  localparam int T_ACK_NS      = 160;
  localparam int T_GAP_NS      = 160;
  localparam int T_SEQ_GAP_NS  = 400;

  // Least times round up to whole cycles.
  localparam int WR_CYC      = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC      = (T_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_CYC     = (T_ACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC     = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_GAP_CYC =
    (T_SEQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] WR_CNT      = CNT_W'(WR_CYC);
  localparam logic [CNT_W-1:0] RD_CNT      = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] ACK_CNT     = CNT_W'(ACK_CYC);
  localparam logic [CNT_W-1:0] GAP_CNT     = CNT_W'(GAP_CYC);
  localparam logic [CNT_W-1:0] SEQ_GAP_CNT = CNT_W'(SEQ_GAP_CYC);
  localparam logic [CNT_W-1:0] ONE_CNT     = 6'h01;

  // ***************************************************************
  // Register map of the host port
  // ***************************************************************
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_WDATA  = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_RDATA  = 8'h10;
  localparam logic [7:0] ADDR_VEC    = 8'h14;

  localparam int CFG_MODE16_BIT   = 0;
  localparam int CFG_AUTO_ACK_BIT = 1;
  localparam int CFG_MASTER_BIT   = 2;
  localparam int CFG_BUFFERED_BIT = 3;
  localparam int CFG_W            = 4;
  localparam logic [CFG_W-1:0] CFG_RST = 4'h0;

  localparam int WDATA_SEL_BIT = 8;
  localparam logic [8:0] WDATA_RST = 9'h000;

  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT  = 1;
  localparam int CMD_ACK_BIT   = 2;

  localparam logic [1:0] ACK_LAST_8BIT  = 2'h2;
  localparam logic [1:0] ACK_LAST_16BIT = 2'h1;
  localparam logic [7:0] BYTE_RST       = 8'h00;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    PH_IDLE, PH_SETUP, PH_PULSE, PH_HOLD, PH_GAP
  } pic_phase_t;

  typedef enum logic [1:0] {
    OP_WRITE, OP_READ, OP_ACK
  } pic_op_t;

endpackage : pic_host_pkg

/* File: pic_timer.sv */
// Down counter that times strobe widths and recovery gaps.
// Assumes the loader holds its phase until o_done is seen.
`timescale 1ns/10ps
module pic_timer (
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rst,
  input  wire logic                           i_load,
  input  wire logic [pic_host_pkg::CNT_W-1:0] i_count,
  output logic                                o_done
);

  logic [pic_host_pkg::CNT_W-1:0] cnt_q;
  logic [pic_host_pkg::CNT_W-1:0] cnt_d;

  // A load of N makes o_done rise in the Nth cycle after the load.
  always_comb begin
    cnt_d = cnt_q;
    if (i_load) begin
      cnt_d = i_count - pic_host_pkg::ONE_CNT;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - pic_host_pkg::ONE_CNT;
    end
  end

  // Counter register.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_done = (cnt_q == '0);

endmodule : pic_timer

/* File: pic_host.sv */
// Host controller that drives an eight-level priority interrupt
// controller through its pins: select, strobes, command select, data
// bus, acknowledge. Software orders cycles through a small register port.
// Assumes all pin inputs are synchronous to i_ref_clk.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps

module pic_host (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  output logic      [31:0] o_rdata,
  output logic             o_cs_n,
  output logic             o_wr_n,
  output logic             o_rd_n,
  output logic             o_command_select,
  output logic             o_irq_ack_n,
  output logic      [7:0]  o_data_out,
  output logic             o_data_oe,
  input  wire logic [7:0]  i_data_in,
  input  wire logic        i_int,
  input  wire logic [2:0]  i_chain_id_bus,
  output logic             o_master_sel_or_buf_en,
  output logic             o_master_sel_or_buf_en_oe,
  input  wire logic        i_master_sel_or_buf_en
);

  // ***************************************************************
  // Register port
  // ***************************************************************
  logic [pic_host_pkg::CFG_W-1:0] cfg_q;
  logic [pic_host_pkg::CFG_W-1:0] cfg_d;
  logic [8:0]                     wdata_q;
  logic [8:0]                     wdata_d;
  logic [7:0]                     rbyte_q;
  logic [7:0]                     rbyte_d;
  logic [7:0]                     vec_q [3];
  logic [7:0]                     vec_d [3];
  logic [31:0]                    rdata_d;
  logic [31:0]                    rdata_q;
  logic                           cmd_wr;
  logic                           busy;
  logic                           mode16;
  logic                           auto_ack;

  assign cmd_wr   = i_wr_stb && (i_addr == pic_host_pkg::ADDR_CMD);
  assign mode16   = cfg_q[pic_host_pkg::CFG_MODE16_BIT];
  assign auto_ack = cfg_q[pic_host_pkg::CFG_AUTO_ACK_BIT];

  // ***************************************************************
  // Cycle sequencer
  // ***************************************************************
  pic_host_pkg::pic_phase_t       phase_q;
  pic_host_pkg::pic_phase_t       phase_d;
  pic_host_pkg::pic_op_t          op_q;
  pic_host_pkg::pic_op_t          op_d;
  logic [1:0]                     idx_q;
  logic [1:0]                     idx_d;
  logic [1:0]                     ack_last;
  logic                           t_load;
  logic [pic_host_pkg::CNT_W-1:0] t_count;
  logic                           t_done;

  assign busy     = (phase_q != pic_host_pkg::PH_IDLE);
  // The wide processor takes two pulses, the byte processor three.
  assign ack_last = mode16 ? pic_host_pkg::ACK_LAST_16BIT
                           : pic_host_pkg::ACK_LAST_8BIT;

  pic_timer u_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_load    (t_load),
    .i_count   (t_count),
    .o_done    (t_done)
  );

  // Phase walk: idle, select setup, strobe low, select hold, recovery.
  // Acknowledge skips setup and hold since it never uses chip select.
  always_comb begin
    phase_d = phase_q;
    op_d    = op_q;
    idx_d   = idx_q;
    t_load  = 1'b0;
    t_count = pic_host_pkg::GAP_CNT;
    rbyte_d = rbyte_q;
    vec_d   = vec_q;
    case (phase_q)
      pic_host_pkg::PH_IDLE: begin
        if (auto_ack && i_int) begin
          // Interrupt level is trusted to stand until this pulse.
          op_d    = pic_host_pkg::OP_ACK;
          idx_d   = 2'h0;
          phase_d = pic_host_pkg::PH_PULSE;
          t_load  = 1'b1;
          t_count = pic_host_pkg::ACK_CNT;
        end else if (cmd_wr && i_wdata[pic_host_pkg::CMD_WRITE_BIT]) begin
          op_d    = pic_host_pkg::OP_WRITE;
          phase_d = pic_host_pkg::PH_SETUP;
        end else if (cmd_wr && i_wdata[pic_host_pkg::CMD_READ_BIT]) begin
          op_d    = pic_host_pkg::OP_READ;
          phase_d = pic_host_pkg::PH_SETUP;
        end else if (cmd_wr && i_wdata[pic_host_pkg::CMD_ACK_BIT]) begin
          op_d    = pic_host_pkg::OP_ACK;
          idx_d   = 2'h0;
          phase_d = pic_host_pkg::PH_PULSE;
          t_load  = 1'b1;
          t_count = pic_host_pkg::ACK_CNT;
        end
      end
      pic_host_pkg::PH_SETUP: begin
        phase_d = pic_host_pkg::PH_PULSE;
        t_load  = 1'b1;
        t_count = (op_q == pic_host_pkg::OP_WRITE) ? pic_host_pkg::WR_CNT
                                                   : pic_host_pkg::RD_CNT;
      end
      pic_host_pkg::PH_PULSE: begin
        if (t_done) begin
          // Sample in the last low cycle, well after data valid time.
          if (op_q == pic_host_pkg::OP_READ) begin
            rbyte_d = i_data_in;
          end
          if (op_q == pic_host_pkg::OP_ACK) begin
            // In wide mode the first pulse finds the bus idle.
            if (!(mode16 && idx_q == 2'h0)) begin
              vec_d[idx_q] = i_data_in;
            end
            phase_d = pic_host_pkg::PH_GAP;
            t_load  = 1'b1;
            t_count = (idx_q == ack_last) ? pic_host_pkg::SEQ_GAP_CNT
                                          : pic_host_pkg::GAP_CNT;
          end else begin
            phase_d = pic_host_pkg::PH_HOLD;
          end
        end
      end
      pic_host_pkg::PH_HOLD: begin
        phase_d = pic_host_pkg::PH_GAP;
        t_load  = 1'b1;
        t_count = pic_host_pkg::SEQ_GAP_CNT;
      end
      pic_host_pkg::PH_GAP: begin
        if (t_done) begin
          if (op_q == pic_host_pkg::OP_ACK && idx_q != ack_last) begin
            idx_d   = idx_q + 2'h1;
            phase_d = pic_host_pkg::PH_PULSE;
            t_load  = 1'b1;
            t_count = pic_host_pkg::ACK_CNT;
          end else begin
            phase_d = pic_host_pkg::PH_IDLE;
          end
        end
      end
      default: begin
        phase_d = pic_host_pkg::PH_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // Pin drive
  // ***************************************************************
  logic       cs_n_d;
  logic       wr_n_d;
  logic       rd_n_d;
  logic       ack_n_d;
  logic       oe_d;
  logic       cs_n_q;
  logic       wr_n_q;
  logic       rd_n_q;
  logic       ack_n_q;
  logic       oe_q;
  logic       sel_q;
  logic [7:0] dout_q;
  logic       in_cycle;

  // Pins are registered from the next phase so strobes never glitch.
  always_comb begin
    in_cycle = (phase_d == pic_host_pkg::PH_SETUP) ||
               (phase_d == pic_host_pkg::PH_PULSE) ||
               (phase_d == pic_host_pkg::PH_HOLD);
    cs_n_d  = !(in_cycle && op_d != pic_host_pkg::OP_ACK);
    wr_n_d  = !(phase_d == pic_host_pkg::PH_PULSE &&
                op_d == pic_host_pkg::OP_WRITE);
    rd_n_d  = !(phase_d == pic_host_pkg::PH_PULSE &&
                op_d == pic_host_pkg::OP_READ);
    ack_n_d = !(phase_d == pic_host_pkg::PH_PULSE &&
                op_d == pic_host_pkg::OP_ACK);
    // Only a write drives the shared bus; reads and vectors float it.
    oe_d    = in_cycle && op_d == pic_host_pkg::OP_WRITE;
  end

  // Pin registers. Command select and data are frozen for a cycle.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
      rd_n_q  <= 1'b1;
      ack_n_q <= 1'b1;
      oe_q    <= 1'b0;
      sel_q   <= 1'b0;
      dout_q  <= pic_host_pkg::BYTE_RST;
    end else begin
      cs_n_q  <= cs_n_d;
      wr_n_q  <= wr_n_d;
      rd_n_q  <= rd_n_d;
      ack_n_q <= ack_n_d;
      oe_q    <= oe_d;
      if (phase_q == pic_host_pkg::PH_IDLE) begin
        sel_q  <= wdata_q[pic_host_pkg::WDATA_SEL_BIT];
        dout_q <= wdata_q[7:0];
      end
    end
  end

  assign o_cs_n           = cs_n_q;
  assign o_wr_n           = wr_n_q;
  assign o_rd_n           = rd_n_q;
  assign o_irq_ack_n      = ack_n_q;
  assign o_data_oe        = oe_q;
  assign o_data_out       = dout_q;
  assign o_command_select = sel_q;
  // Tie of the mode pin; released in buffered mode, where it is driven.
  assign o_master_sel_or_buf_en    = cfg_q[pic_host_pkg::CFG_MASTER_BIT];
  assign o_master_sel_or_buf_en_oe =
    !cfg_q[pic_host_pkg::CFG_BUFFERED_BIT];

  // ***************************************************************
  // Register writes and read decode
  // ***************************************************************
  // Data and select writes are dropped while a cycle runs, so pins never move.
  always_comb begin
    cfg_d   = cfg_q;
    wdata_d = wdata_q;
    rdata_d = 32'h0000_0000;
    if (i_wr_stb && i_addr == pic_host_pkg::ADDR_CFG) begin
      cfg_d = i_wdata[pic_host_pkg::CFG_W-1:0];
    end else if (i_wr_stb && i_addr == pic_host_pkg::ADDR_WDATA &&
                 !busy) begin
      wdata_d = i_wdata[8:0];
    end
    if (i_rd_stb) begin
      if (i_addr == pic_host_pkg::ADDR_CFG) begin
        rdata_d = {28'h000_0000, cfg_q};
      end else if (i_addr == pic_host_pkg::ADDR_WDATA) begin
        rdata_d = {23'h00_0000, wdata_q};
      end else if (i_addr == pic_host_pkg::ADDR_STATUS) begin
        // Chain id lines are only watched; the device drives them.
        rdata_d = {26'h000_0000, i_chain_id_bus,
                   i_master_sel_or_buf_en, i_int, busy};
      end else if (i_addr == pic_host_pkg::ADDR_RDATA) begin
        rdata_d = {24'h00_0000, rbyte_q};
      end else if (i_addr == pic_host_pkg::ADDR_VEC) begin
        rdata_d = {8'h00, vec_q[2], vec_q[1], vec_q[0]};
      end
    end
  end

  // State and register flops.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_q <= pic_host_pkg::PH_IDLE;
      op_q    <= pic_host_pkg::OP_WRITE;
      idx_q   <= 2'h0;
      cfg_q   <= pic_host_pkg::CFG_RST;
      wdata_q <= pic_host_pkg::WDATA_RST;
      rbyte_q <= pic_host_pkg::BYTE_RST;
      vec_q   <= '{default: pic_host_pkg::BYTE_RST};
      rdata_q <= 32'h0000_0000;
    end else begin
      phase_q <= phase_d;
      op_q    <= op_d;
      idx_q   <= idx_d;
      cfg_q   <= cfg_d;
      wdata_q <= wdata_d;
      rbyte_q <= rbyte_d;
      vec_q   <= vec_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // ***************************************************************
  // Checks
  // ***************************************************************
  localparam int WR_LAST  = pic_host_pkg::WR_CYC - 1;
  localparam int ACK_LAST = pic_host_pkg::ACK_CYC - 1;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_strobe_with_cs: assert property (
    (!o_wr_n || !o_rd_n) |-> !o_cs_n)
    else $error("strobe low without chip select");
  a_ack_cs_free: assert property (
    !o_irq_ack_n |-> (o_cs_n && o_wr_n && o_rd_n))
    else $error("acknowledge overlaps a select cycle");
  a_write_width: assert property (
    $fell(o_wr_n) |-> o_data_oe ##WR_LAST (!o_wr_n && o_data_oe) ##1
    (o_wr_n && !o_cs_n && o_data_oe))
    else $error("write pulse width or data hold wrong");
  a_bus_released: assert property (
    (!o_rd_n || !o_irq_ack_n) |-> !o_data_oe)
    else $error("host drives bus while device may");
  a_select_stable: assert property (
    (!o_cs_n && !$fell(o_cs_n)) |-> $stable(o_command_select))
    else $error("command select moved during a cycle");
  a_auto_ack_start: assert property (
    (auto_ack && i_int && !busy) |=> $fell(o_irq_ack_n))
    else $error("interrupt not acknowledged");
  a_ack_width: assert property (
    $fell(o_irq_ack_n) |-> ##ACK_LAST !o_irq_ack_n ##1 o_irq_ack_n[*8])
    else $error("acknowledge pulse width or gap wrong");
  a_read_capture: assert property (
    ($rose(o_rd_n)) |-> (rbyte_q == $past(i_data_in)))
    else $error("read byte not captured at strobe end");
  a_wide_skip: assert property (
    (mode16 && phase_q == pic_host_pkg::PH_PULSE && idx_q == 2'h0 &&
     op_q == pic_host_pkg::OP_ACK) |=> $stable(vec_q[0]))
    else $error("first wide acknowledge byte was stored");

endmodule : pic_host

/* File: pic_dev_model.sv */
// Behavioural model of the eight-level interrupt controller device.
// Assumes host pins are synchronous to i_ref_clk; level-triggered mode.
`timescale 1ns/10ps
module pic_dev_model #(
  parameter logic [7:0] CALL_OP  = 8'hcd,
  parameter logic [2:0] LO_TOP   = 3'h5,
  parameter logic [7:0] HI_ADDR  = 8'h5a,
  parameter logic [4:0] PTR_BASE = 5'h11
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_cs_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_command_select,
  input  wire logic       i_irq_ack_n,
  input  wire logic [7:0] i_data,
  input  wire logic [7:0] i_request_lines,
  input  wire logic       i_mode16,
  input  wire logic       i_buffered,
  input  wire logic       i_master_sel,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  output logic            o_int,
  output logic      [2:0] o_chain_id_bus,
  output logic            o_buf_en_n,
  output logic            o_buf_en_oe
);
  // ***************************************************************
  // Priority resolver
  // ***************************************************************
  logic [7:0] mask_q, serviced_q, elig, above;
  logic [2:0] level_q, top;
  logic [1:0] idx_q;
  logic       rd_sel_q, wr_q, ack_q, int_q, has_req;

  // Lowest line index wins; a level only counts above those in service.
  always_comb begin
    elig = i_request_lines & ~mask_q;
    above = 8'hff;
    top = 3'h7;
    has_req = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (serviced_q[i]) above = (8'h01 << i) - 8'h01;
      if (elig[i]) begin
        top = i[2:0];
        has_req = 1'b1;
      end
    end
  end

  // ***************************************************************
  // Data bus, chain id and transceiver enable
  // ***************************************************************
  // The bus is driven for a selected read or an acknowledge pulse, except the first pulse in wide mode.
  assign o_data_oe = (!i_cs_n && !i_rd_n)
    || (!i_irq_ack_n && !(i_mode16 && idx_q == 2'd0));
  always_comb begin
    if (!i_irq_ack_n) begin
      case (idx_q)
        2'd0:    o_data = CALL_OP;
        2'd1:    o_data = i_mode16 ? {PTR_BASE, level_q}
                                   : {LO_TOP, level_q, 2'b00};
        default: o_data = HI_ADDR;
      endcase
    end else if (i_command_select) o_data = mask_q;
    else o_data = rd_sel_q ? serviced_q : i_request_lines;
  end
  // A slave leaves the chain lines to others; the inverted level stands in.
  assign o_chain_id_bus = (i_master_sel && !i_buffered) ? level_q
                                                        : ~level_q;
  assign o_buf_en_oe = i_buffered;
  assign o_buf_en_n  = !o_data_oe;
  assign o_int       = int_q;

  // ***************************************************************
  // Command latch and acknowledge sequence
  // ***************************************************************
  // Writes land on the rising write strobe while still selected.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_q     <= 8'h00;
      serviced_q <= 8'h00;
      level_q    <= 3'h7;
      idx_q      <= 2'd0;
      rd_sel_q   <= 1'b0;
      wr_q       <= 1'b1;
      ack_q      <= 1'b1;
      int_q      <= 1'b0;
    end else begin
      wr_q  <= i_wr_n;
      ack_q <= i_irq_ack_n;
      if (!i_cs_n && !wr_q && i_wr_n) begin
        if (i_command_select) mask_q <= i_data;
        else if (i_data[5]) serviced_q <= serviced_q & (serviced_q - 8'h01);
        else if (i_data[3]) rd_sel_q <= i_data[0];
      end
      if (ack_q && !i_irq_ack_n && idx_q == 2'd0) begin
        level_q <= top;
        if (has_req) serviced_q[top] <= 1'b1;
      end
      if (!ack_q && i_irq_ack_n)
        idx_q <= (idx_q == (i_mode16 ? 2'd1 : 2'd2)) ? 2'd0 : idx_q + 2'd1;
      if (ack_q && !i_irq_ack_n) int_q <= 1'b0;
      else if (|(elig & above)) int_q <= 1'b1;
    end
  end
endmodule : pic_dev_model

/* File: pic_host_tb.sv */
// Self-checking bench for the interrupt controller host front end.
// Assumes pic_dev_model stands for the device on the far side.
`timescale 1ns/10ps
module pic_host_tb;
  // ***************************************************************
  // Signals and far-side wiring
  // ***************************************************************
  localparam logic [7:0] CALL_OP  = 8'hcd;
  localparam logic [2:0] LO_TOP   = 3'h5;
  localparam logic [7:0] HI_ADDR  = 8'h5a;
  localparam logic [4:0] PTR_BASE = 5'h11;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] msk;
  } pic_note_t;
  logic        clk, rst, wr_stb, rd_stb, rd_seen, mode16, buffered;
  logic        cs_n, wr_n, rd_n, csel, ack_n, h_oe, d_oe, irq;
  logic        ms_out, ms_oe, ms_pin, en_n, en_oe;
  logic [7:0]  addr, req, flt, bus, d_out, h_out, m, rq;
  logic [3:0]  lv;
  logic [2:0]  chain;
  logic [31:0] wdata, rdata;
  int          fail_count, samples_checked, cyc, oe_cnt, en_cnt, seed;
  pic_note_t   notes[$];
  pic_note_t   note;

  // Released lines show a pattern that changes every cycle.
  assign bus    = h_oe ? h_out : (d_oe ? d_out : flt);
  assign ms_pin = ms_oe ? ms_out : (en_oe ? en_n : flt[0]);
  always #5 clk = ~clk;

  pic_host uut (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rdata(rdata),
    .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n), .o_command_select(csel),
    .o_irq_ack_n(ack_n), .o_data_out(h_out), .o_data_oe(h_oe),
    .i_data_in(bus), .i_int(irq), .i_chain_id_bus(chain),
    .o_master_sel_or_buf_en(ms_out), .o_master_sel_or_buf_en_oe(ms_oe),
    .i_master_sel_or_buf_en(ms_pin));
  pic_dev_model #(.CALL_OP(CALL_OP), .LO_TOP(LO_TOP), .HI_ADDR(HI_ADDR),
    .PTR_BASE(PTR_BASE)) dev (.i_ref_clk(clk), .i_rst(rst), .i_cs_n(cs_n),
    .i_wr_n(wr_n), .i_rd_n(rd_n), .i_command_select(csel),
    .i_irq_ack_n(ack_n), .i_data(bus), .i_request_lines(req),
    .i_mode16(mode16), .i_buffered(buffered), .i_master_sel(ms_pin),
    .o_data(d_out), .o_data_oe(d_oe), .o_int(irq), .o_chain_id_bus(chain),
    .o_buf_en_n(en_n), .o_buf_en_oe(en_oe));

  // ***************************************************************
  // Checking and register bus tasks
  // ***************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("compared %0d mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // The note goes in before the strobe so the watcher finds it waiting.
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] mk);
    notes.push_back('{e, mk});
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask : rd

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(pic_host_pkg::ADDR_STATUS, 32'h0, 32'h0);
      @(negedge clk);
      n++;
    end while (rdata[0] !== 1'b0 && n < 300);
    if (n >= 300) begin
      fail_count++;
      end_of_test();
    end
  endtask : wait_idle

  task automatic dev_wr(input logic cs, input logic [7:0] b);
    wr(pic_host_pkg::ADDR_WDATA, {23'h0, cs, b});
    wr(pic_host_pkg::ADDR_CMD, 32'h0000_0001);
    wait_idle();
  endtask : dev_wr

  task automatic dev_rd(input logic cs, input logic [7:0] e);
    wr(pic_host_pkg::ADDR_WDATA, {23'h0, cs, 8'h00});
    wr(pic_host_pkg::ADDR_CMD, 32'h0000_0002);
    wait_idle();
    rd(pic_host_pkg::ADDR_RDATA, {24'h0, e}, 32'h0000_00ff);
  endtask : dev_rd

  // Automatic mode lets the interrupt start the sequence by itself.
  task automatic ack_vec(input logic [2:0] l, input logic auto);
    oe_cnt = 0;
    if (auto) repeat (4) @(posedge clk);
    else wr(pic_host_pkg::ADDR_CMD, 32'h0000_0004);
    wait_idle();
    if (mode16)
      rd(pic_host_pkg::ADDR_VEC, {16'h0, PTR_BASE, l, 8'h0}, 32'h0000_ff00);
    else
      rd(pic_host_pkg::ADDR_VEC, {8'h0, HI_ADDR, LO_TOP, l, 2'b00, CALL_OP},
         32'h00ff_ffff);
    check(32'(oe_cnt), 32'(pic_host_pkg::ACK_CYC * (mode16 ? 1 : 3)));
  endtask : ack_vec

  function automatic logic [3:0] exp_level(input logic [7:0] e);
    exp_level = 4'h7;
    for (int i = 7; i >= 0; i--) if (e[i]) exp_level = {1'b1, i[2:0]};
  endfunction : exp_level

  // ***************************************************************
  // Watchers and sequence
  // ***************************************************************
  always @(posedge clk) begin
    flt     <= ~flt;
    rd_seen <= rd_stb;
    cyc++;
    if (!ack_n && d_oe) oe_cnt++;
    if (en_oe && !en_n) en_cnt++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  // Read data stand only in the cycle after the strobe.
  always @(negedge clk) begin
    if (rd_seen && notes.size() > 0) begin
      note = notes.pop_front();
      if (note.msk != 32'h0) check(rdata & note.msk, note.exp);
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {addr, wdata, wr_stb, rd_stb, rd_seen, req, mode16, buffered} = '0;
    flt = 8'h5a;
    seed = 63;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(pic_host_pkg::ADDR_CFG, 32'h0, 32'hffff_ffff);
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, 32'h0, 32'hffff_ffff);
    rd(pic_host_pkg::ADDR_CFG, 32'h0, 32'hffff_ffff);
    @(negedge clk);
    check(32'({cs_n, wr_n, rd_n, ack_n, h_oe}), 32'h0000_001e);
    wr(pic_host_pkg::ADDR_CFG, 32'h0000_0004);
    for (int k = 0; k < 5; k++) begin
      m  = 8'($random(seed));
      rq = (k == 0) ? 8'h00 : 8'($random(seed));
      dev_wr(1'b1, m);
      check(32'(dev.mask_q), 32'(m));
      dev_wr(1'b0, 8'h0a);
      req <= rq;
      dev_rd(1'b0, rq);
      lv = exp_level(rq & ~m);
      rd(pic_host_pkg::ADDR_STATUS, {30'h0, lv[3], 1'b0}, 32'h3);
      ack_vec(lv[2:0], 1'b0);
      rd(pic_host_pkg::ADDR_STATUS, 32'({lv[2:0], 3'b100}), 32'h3f);
      dev_wr(1'b0, 8'h0b);
      dev_rd(1'b0, lv[3] ? (8'h01 << lv[2:0]) : 8'h00);
      req <= 8'h00;
      dev_wr(1'b0, 8'h20);
    end
    dev_wr(1'b1, 8'h00);
    req <= 8'h04;
    ack_vec(3'h2, 1'b0);
    req <= 8'h24;
    repeat (4) @(posedge clk);
    rd(pic_host_pkg::ADDR_STATUS, 32'h0, 32'h2);
    req <= 8'h25;
    repeat (4) @(posedge clk);
    rd(pic_host_pkg::ADDR_STATUS, 32'h2, 32'h2);
    ack_vec(3'h0, 1'b0);
    dev_wr(1'b0, 8'h0b);
    dev_rd(1'b0, 8'h05);
    req <= 8'h00;
    dev_wr(1'b0, 8'h20);
    dev_wr(1'b0, 8'h20);
    wr(pic_host_pkg::ADDR_CFG, 32'h0000_0001);
    mode16 <= 1'b1;
    req    <= 8'h40;
    ack_vec(3'h6, 1'b0);
    req    <= 8'h00;
    dev_wr(1'b0, 8'h20);
    mode16 <= 1'b0;
    wr(pic_host_pkg::ADDR_CFG, 32'h0000_0002);
    req <= 8'h08;
    ack_vec(3'h3, 1'b1);
    wr(pic_host_pkg::ADDR_CFG, 32'h0000_0008);
    req      <= 8'h00;
    buffered <= 1'b1;
    dev_wr(1'b0, 8'h20);
    check(32'(ms_oe), 32'h0);
    en_cnt = 0;
    dev_rd(1'b1, 8'h00);
    check(32'(en_cnt), 32'(pic_host_pkg::RD_CYC));
    rd(pic_host_pkg::ADDR_STATUS, 32'h4, 32'h4);
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule : pic_host_tb
